// ===== inc/card_cmd_map.svh
/*
  Register offsets, command word fields, status words and coding values for the card
  command interpreter.
  Assumes a byte-addressed register port with one 32-bit word per register.
*/
`ifndef CARD_CMD_MAP_SVH
`define CARD_CMD_MAP_SVH

// register byte offsets
`define REG_CMD 8'h00
`define REG_ARG 8'h04
`define REG_STATUS 8'h08
`define REG_FILE 8'h0c
`define REG_LIFE 8'h10
`define REG_DEACT_OK 8'h14
`define REG_ACT_OK 8'h18
`define REG_CTRL 8'h1c
`define REG_RESP 8'h20

// command word fields
`define F_P1 7:0
`define F_P2 15:8
`define F_LEN 23:16
`define F_TGT 27:24
`define F_OP 30:28
`define F_LE 31
// argument word fields
`define F_TOTAL 15:0
`define F_TAG 23:16
`define F_DF 27:24
// status, file and response word fields
`define F_SW 15:0
`define F_BUSY 16
`define F_CUREF 3:0
`define F_CURDF 7:4
`define F_OFF 15:0
`define F_SEG 24:16

// reset values
`define RST_WORD 32'h0000_0000
`define RST_SW 16'h9000

// status words
`define SW_OK 16'h9000
`define SW_DATA_MORE 16'h63f1
`define SW_DATA_DONE 16'h62f3
`define SW_RESP_MORE 16'h62f1
`define SW_WRONG_LEN 16'h6700
`define SW_BAD_P1P2 16'h6a86
`define SW_BAD_DATA 16'h6a80
`define SW_SECURITY 16'h6982
`define SW_SEQUENCE 16'h6985
`define SW_DEAD_FILE 16'h6283

// parameter coding
`define P_ZERO 8'h00
`define P1_PATH_MF 8'h08
`define P1_PATH_DF 8'h09
`define LEN_UNBLOCK 8'h10
`define TAG_TLV 8'h73
`define TAG_PLAIN 8'h53
`define ROLE_DATA_FIRST 3'b100
`define ROLE_DATA_NEXT 3'b000
`define ROLE_DATA_RETX 3'b010
`define ROLE_RESP_FIRST 3'b101
`define ROLE_RESP_NEXT 3'b001
`define ROLE_RESP_RETX 3'b011
`define LE_FULL 9'h100

`endif

// ===== inc/card_cmd_pkg.sv
/*
  Types of the card command interpreter: command kinds and state codes.
  Assumes the map header supplies all numeric constants.
*/
package card_cmd_pkg;

  typedef enum logic [2:0] {
    OP_UNBLOCK = 3'h0,
    OP_DEACT = 3'h1,
    OP_ACT = 3'h2,
    OP_AUTH_EVEN = 3'h3,
    OP_AUTH_ODD = 3'h4,
    OP_SELECT = 3'h5,
    OP_OTHER = 3'h6,
    OP_SPARE = 3'h7
  } op_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_EXEC = 3'b010,
    C_WAIT = 3'b100
  } cmd_state_t;

  typedef enum logic [3:0] {
    CH_IDLE = 4'b0001,
    CH_RX = 4'b0010,
    CH_RXDONE = 4'b0100,
    CH_TX = 4'b1000
  } chain_state_t;

endpackage : card_cmd_pkg

// ===== verilog/card_file_state_and_auth_chaining.sv
/*
  Card command interpreter: parameter checks of PIN unblocking, elementary file
  deactivation and reactivation with current-file tracking, and the chained
  authenticate command with its status words.
  Assumes firmware writes the argument word and then the command word, resolves file
  paths to a file index, and that the authentication engine runs on clk.
*/
// Function
// - unblock takes P1 zero, no Le, length empty or sixteen
// - deactivation needs its access condition and marks the file deactivated
// - activation needs its access condition and clears the deactivated mark
// - successful deactivate or activate makes the target the current file
// - failed deactivate or activate keeps current file and directory unchanged
// - deactivated file refuses only OP_OTHER; select, deactivation and activation still act on it
// - selection byte is zero, path from root, or path from directory
// - P2 zero, no Le; all-empty command acts on current file
// - odd code carries TLV challenge and response of any length
// - odd-code data is wrapped under tag 73 or 53
// - chained data blocks hold at most 255 bytes, response segments at most 256, role given in P1
// - card answers 63F1 while data missing, 62F3 when complete
// - first response block starts the authentication computation
// - card answers 62F1 while response remains, 9000 on last segment
// - top three P1 bits give block role
`timescale 1ns/1ps
`include "card_cmd_map.svh"

module card_file_state_and_auth_chaining #(
  parameter int NUM_FILES = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [31:0] rdData,
  output logic authStart,
  input wire logic authDone,
  input wire logic [15:0] authRespLen
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  card_cmd_pkg::cmd_state_t cState, next_cState;
  card_cmd_pkg::chain_state_t chain, next_chain;
  logic [31:0] cmd, next_cmd;
  logic [31:0] arg, next_arg;
  logic [15:0] sw, next_sw;
  logic [3:0] curEf, next_curEf;
  logic [3:0] curDf, next_curDf;
  logic [NUM_FILES-1:0] lifeOff, next_lifeOff;
  logic [NUM_FILES-1:0] deactOk, next_deactOk;
  logic [NUM_FILES-1:0] actOk, next_actOk;
  logic appSel, next_appSel;
  logic [15:0] rxCount, next_rxCount;
  logic [15:0] rxTotal, next_rxTotal;
  logic [7:0] lastRx, next_lastRx;
  logic [15:0] respLen, next_respLen;
  logic [15:0] respOff, next_respOff;
  logic [8:0] segLen, next_segLen;
  logic pendEven, next_pendEven;
  logic next_authStart;
  logic [31:0] next_rdData;

  card_cmd_pkg::op_t op;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] len;
  logic [2:0] role;
  logic [3:0] tgt;
  logic exec;

  assign op = card_cmd_pkg::op_t'(cmd[`F_OP]);
  assign p1 = cmd[`F_P1];
  assign p2 = cmd[`F_P2];
  assign len = cmd[`F_LEN];
  assign role = p1[7:5];
  assign tgt = (p1 == `P_ZERO && len == `P_ZERO) ? curEf : cmd[`F_TGT];
  assign exec = (cState == card_cmd_pkg::C_EXEC);

  // size of the next response segment: Le of zero asks for 256
  function automatic logic [8:0] seg_size(input logic [7:0] le, input logic [15:0] left);
    logic [8:0] want;
    want = (le == `P_ZERO) ? `LE_FULL : {1'b0, le};
    seg_size = ({7'h00, want} < left) ? want : left[8:0];
  endfunction : seg_size

  // status for a response segment starting at off
  function automatic logic [15:0] resp_sw(input logic [15:0] off, input logic [8:0] seg,
                                          input logic [15:0] total);
    resp_sw = ((off + {7'h00, seg}) < total) ? `SW_RESP_MORE : `SW_OK;
  endfunction : resp_sw

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_cState = cState;
    next_chain = chain;
    next_cmd = cmd;
    next_arg = arg;
    next_sw = sw;
    next_curEf = curEf;
    next_curDf = curDf;
    next_lifeOff = lifeOff;
    next_deactOk = deactOk;
    next_actOk = actOk;
    next_appSel = appSel;
    next_rxCount = rxCount;
    next_rxTotal = rxTotal;
    next_lastRx = lastRx;
    next_respLen = respLen;
    next_respOff = respOff;
    next_segLen = segLen;
    next_pendEven = pendEven;
    next_authStart = 1'b0;
    next_rdData = `RST_WORD;

    if (rdStb) begin
      unique case (addr)
        `REG_CMD: next_rdData = cmd;
        `REG_ARG: next_rdData = arg;
        `REG_STATUS: next_rdData = {15'h0000, cState != card_cmd_pkg::C_IDLE, sw};
        `REG_FILE: next_rdData = {24'h000000, curDf, curEf};
        `REG_LIFE: next_rdData = 32'(lifeOff);
        `REG_DEACT_OK: next_rdData = 32'(deactOk);
        `REG_ACT_OK: next_rdData = 32'(actOk);
        `REG_CTRL: next_rdData = {31'h00000000, appSel};
        `REG_RESP: next_rdData = {7'h00, segLen, respOff};
        default: next_rdData = `RST_WORD;
      endcase
    end

    if (wrStb) begin
      unique case (addr)
        `REG_CMD: begin
          if (cState == card_cmd_pkg::C_IDLE) begin
            next_cmd = wrData;
            next_cState = card_cmd_pkg::C_EXEC;
          end
        end
        `REG_ARG: next_arg = wrData;
        `REG_DEACT_OK: next_deactOk = wrData[NUM_FILES-1:0];
        `REG_ACT_OK: next_actOk = wrData[NUM_FILES-1:0];
        `REG_CTRL: next_appSel = wrData[0];
        default: ;
      endcase
    end

    unique case (cState)
      card_cmd_pkg::C_IDLE: ;
      card_cmd_pkg::C_EXEC: begin
        next_cState = card_cmd_pkg::C_IDLE;
        next_sw = `SW_OK;
        unique case (op)
          card_cmd_pkg::OP_UNBLOCK: begin
            if (p1 != `P_ZERO || cmd[`F_LE]) begin
              next_sw = `SW_BAD_P1P2;
            end else if (len != `P_ZERO && len != `LEN_UNBLOCK) begin
              next_sw = `SW_WRONG_LEN;
            end
          end
          card_cmd_pkg::OP_DEACT, card_cmd_pkg::OP_ACT: begin
            if (p2 != `P_ZERO || cmd[`F_LE] ||
                (p1 != `P_ZERO && p1 != `P1_PATH_MF && p1 != `P1_PATH_DF)) begin
              next_sw = `SW_BAD_P1P2;
            end else if (p1 != `P_ZERO && len == `P_ZERO) begin
              next_sw = `SW_WRONG_LEN;
            end else if (op == card_cmd_pkg::OP_DEACT && !deactOk[tgt]) begin
              next_sw = `SW_SECURITY;
            end else if (op == card_cmd_pkg::OP_ACT && !actOk[tgt]) begin
              next_sw = `SW_SECURITY;
            end else begin
              next_lifeOff[tgt] = (op == card_cmd_pkg::OP_DEACT);
              next_curEf = tgt;
            end
          end
          card_cmd_pkg::OP_SELECT: begin
            next_curEf = cmd[`F_TGT];
            next_curDf = arg[`F_DF];
          end
          card_cmd_pkg::OP_OTHER: begin
            if (lifeOff[cmd[`F_TGT]]) begin
              next_sw = `SW_DEAD_FILE;
            end
          end
          card_cmd_pkg::OP_AUTH_EVEN: begin
            if (p1 != `P_ZERO) begin
              next_sw = `SW_BAD_P1P2;
            end else if (!appSel || len == `P_ZERO) begin
              next_sw = appSel ? `SW_WRONG_LEN : `SW_SEQUENCE;
            end else begin
              next_authStart = 1'b1;
              next_pendEven = 1'b1;
              next_chain = card_cmd_pkg::CH_IDLE;
              next_cState = card_cmd_pkg::C_WAIT;
            end
          end
          card_cmd_pkg::OP_AUTH_ODD: begin
            if (!appSel) begin
              next_sw = `SW_SEQUENCE;
            end else begin
              unique case (role)
                `ROLE_DATA_FIRST: begin
                  if (arg[`F_TAG] != `TAG_TLV && arg[`F_TAG] != `TAG_PLAIN) begin
                    next_sw = `SW_BAD_DATA;
                  end else if (len == `P_ZERO) begin
                    next_sw = `SW_WRONG_LEN;
                  end else begin
                    next_rxTotal = arg[`F_TOTAL];
                    next_rxCount = {8'h00, len};
                    next_lastRx = len;
                    next_sw = ({8'h00, len} < arg[`F_TOTAL]) ? `SW_DATA_MORE : `SW_DATA_DONE;
                    next_chain = ({8'h00, len} < arg[`F_TOTAL]) ? card_cmd_pkg::CH_RX
                                                                : card_cmd_pkg::CH_RXDONE;
                  end
                end
                `ROLE_DATA_NEXT, `ROLE_DATA_RETX: begin
                  if (chain != card_cmd_pkg::CH_RX &&
                      !(role == `ROLE_DATA_RETX && chain == card_cmd_pkg::CH_RXDONE)) begin
                    next_sw = `SW_SEQUENCE;
                  end else begin
                    // concatenate segments, a retransmit replaces the last one
                    next_rxCount = (role == `ROLE_DATA_RETX) ?
                                   rxCount - {8'h00, lastRx} + {8'h00, len} :
                                   rxCount + {8'h00, len};
                    next_lastRx = len;
                    next_sw = (next_rxCount < rxTotal) ? `SW_DATA_MORE : `SW_DATA_DONE;
                    next_chain = (next_rxCount < rxTotal) ? card_cmd_pkg::CH_RX
                                                          : card_cmd_pkg::CH_RXDONE;
                  end
                end
                `ROLE_RESP_FIRST: begin
                  if (chain != card_cmd_pkg::CH_RXDONE) begin
                    next_sw = `SW_SEQUENCE;
                  end else begin
                    next_authStart = 1'b1;
                    next_pendEven = 1'b0;
                    next_cState = card_cmd_pkg::C_WAIT;
                  end
                end
                `ROLE_RESP_NEXT, `ROLE_RESP_RETX: begin
                  if (chain != card_cmd_pkg::CH_TX ||
                      (role == `ROLE_RESP_NEXT && respOff + {7'h00, segLen} >= respLen)) begin
                    next_sw = `SW_SEQUENCE;
                  end else begin
                    if (role == `ROLE_RESP_NEXT) begin
                      next_respOff = respOff + {7'h00, segLen};
                    end
                    next_segLen = seg_size(len, respLen - next_respOff);
                    next_sw = resp_sw(next_respOff, next_segLen, respLen);
                  end
                end
                default: next_sw = `SW_BAD_P1P2;
              endcase
            end
          end
          default: next_sw = `SW_BAD_P1P2;
        endcase
      end
      card_cmd_pkg::C_WAIT: begin
        if (authDone) begin
          next_cState = card_cmd_pkg::C_IDLE;
          next_respLen = authRespLen;
          next_respOff = 16'h0000;
          next_segLen = seg_size(len, authRespLen);
          if (pendEven) begin
            next_sw = `SW_OK;
          end else begin
            next_chain = card_cmd_pkg::CH_TX;
            next_sw = resp_sw(16'h0000, next_segLen, authRespLen);
          end
        end
      end
      default: next_cState = card_cmd_pkg::C_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cState <= card_cmd_pkg::C_IDLE;
      chain <= card_cmd_pkg::CH_IDLE;
      cmd <= `RST_WORD;
      arg <= `RST_WORD;
      sw <= `RST_SW;
      curEf <= 4'h0;
      curDf <= 4'h0;
      lifeOff <= '0;
      deactOk <= '0;
      actOk <= '0;
      appSel <= 1'b0;
      rxCount <= 16'h0000;
      rxTotal <= 16'h0000;
      lastRx <= 8'h00;
      respLen <= 16'h0000;
      respOff <= 16'h0000;
      segLen <= 9'h000;
      pendEven <= 1'b0;
      authStart <= 1'b0;
      rdData <= `RST_WORD;
    end else begin
      cState <= next_cState;
      chain <= next_chain;
      cmd <= next_cmd;
      arg <= next_arg;
      sw <= next_sw;
      curEf <= next_curEf;
      curDf <= next_curDf;
      lifeOff <= next_lifeOff;
      deactOk <= next_deactOk;
      actOk <= next_actOk;
      appSel <= next_appSel;
      rxCount <= next_rxCount;
      rxTotal <= next_rxTotal;
      lastRx <= next_lastRx;
      respLen <= next_respLen;
      respOff <= next_respOff;
      segLen <= next_segLen;
      pendEven <= next_pendEven;
      authStart <= next_authStart;
      rdData <= next_rdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_unblock_len: assert property (exec && op == card_cmd_pkg::OP_UNBLOCK && p1 == `P_ZERO &&
    !cmd[`F_LE] && len != `P_ZERO && len != `LEN_UNBLOCK |=> sw == `SW_WRONG_LEN)
    else $error("unblock length not refused");
  a_deact_guard: assert property (exec && op == card_cmd_pkg::OP_DEACT && !deactOk[tgt]
    |=> lifeOff == $past(lifeOff) && sw != `SW_OK)
    else $error("deactivation without access condition");
  a_act_flag: assert property (exec && op == card_cmd_pkg::OP_ACT
    |=> (sw == `SW_OK) ? (!lifeOff[$past(tgt)] && $past(actOk[tgt])) :
    (lifeOff == $past(lifeOff)))
    else $error("activation flag mismatch");
  a_cur_ef_set: assert property (exec && (op == card_cmd_pkg::OP_DEACT ||
    op == card_cmd_pkg::OP_ACT) |=> sw != `SW_OK || curEf == $past(tgt))
    else $error("current file not updated");
  a_cur_keep: assert property (exec && (op == card_cmd_pkg::OP_DEACT ||
    op == card_cmd_pkg::OP_ACT) |=> sw == `SW_OK || ($stable(curEf) && $stable(curDf)))
    else $error("current file moved on failure");
  a_dead_file: assert property (exec && op == card_cmd_pkg::OP_OTHER &&
    lifeOff[cmd[`F_TGT]] |=> sw == `SW_DEAD_FILE)
    else $error("deactivated file used");
  a_sel_ctrl: assert property (exec && op == card_cmd_pkg::OP_DEACT && p1 != `P_ZERO &&
    p1 != `P1_PATH_MF && p1 != `P1_PATH_DF |=> sw == `SW_BAD_P1P2)
    else $error("reserved selection accepted");
  a_tag_check: assert property (exec && op == card_cmd_pkg::OP_AUTH_ODD && appSel &&
    role == `ROLE_DATA_FIRST && arg[`F_TAG] != `TAG_TLV && arg[`F_TAG] != `TAG_PLAIN
    |=> sw == `SW_BAD_DATA)
    else $error("bad wrapper tag accepted");
  a_data_status: assert property (chain == card_cmd_pkg::CH_RXDONE &&
    $changed(chain) |-> sw == `SW_DATA_DONE && rxCount >= rxTotal)
    else $error("completion status wrong");
  a_start_once: assert property (exec && op == card_cmd_pkg::OP_AUTH_ODD && appSel &&
    role == `ROLE_RESP_FIRST && chain == card_cmd_pkg::CH_RXDONE |=> authStart ##1 !authStart)
    else $error("computation not started");
  a_order: assert property (exec && op == card_cmd_pkg::OP_AUTH_ODD && appSel &&
    role == `ROLE_DATA_NEXT && chain != card_cmd_pkg::CH_RX |=> sw == `SW_SEQUENCE)
    else $error("out of order block accepted");

endmodule : card_file_state_and_auth_chaining

// ===== bench/auth_engine_model.sv
/*
  Behavioural model of the authentication engine that answers the card interpreter.
  Assumes one clock shared with the interpreter; the bench sets the answer delay and length.
*/
`timescale 1ns/1ps

module auth_engine_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic authStart,
  input wire logic [7:0] delay,
  input wire logic [15:0] respLen,
  output logic authDone,
  output logic [15:0] authRespLen
);

  logic running;
  logic [7:0] count;

  ////////////////////////////////////////////////////////////////////////////////
  // the length bus shows the inverse of its last value outside the done pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      count <= 8'h00;
      authDone <= 1'b0;
      authRespLen <= 16'h0000;
    end else begin
      authDone <= 1'b0;
      authRespLen <= ~authRespLen;
      if (authStart) begin
        running <= 1'b1;
        count <= delay;
      end else if (running && count == 8'h00) begin
        running <= 1'b0;
        authDone <= 1'b1;
        authRespLen <= respLen;
      end else if (running) begin
        count <= count - 8'h01;
      end
    end
  end

endmodule : auth_engine_model

// ===== bench/card_file_state_and_auth_chaining_test.sv
/*
  Self-checking bench of the card command interpreter: file commands and chained authenticate.
  Assumes the register map header and the engine model; reads are checked by a monitor queue.
*/
`timescale 1ns/1ps
`include "card_cmd_map.svh"

module card_file_state_and_auth_chaining_test;

  logic clk = 1'b0, rst = 1'b1, wrStb = 1'b0, rdStb = 1'b0, rdChk = 1'b0, pend = 1'b0;
  logic authStart, authDone;
  logic [7:0] addr = 8'h00, dly = 8'h00;
  logic [31:0] wrData = 32'h0, rdData, rdLast;
  logic [15:0] authRespLen, respLen = 16'h012c;
  logic [31:0] expQ[$];
  logic [7:0] p1s[3] = '{8'h00, 8'h08, 8'h09};
  int n_mismatch = 0, checked = 0, nStart = 0, cyc = 0;

  always #5 clk = ~clk;

  card_file_state_and_auth_chaining #(.NUM_FILES(16)) card_file_state_and_auth_chaining_inst (
    .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .authStart(authStart), .authDone(authDone), .authRespLen(authRespLen));

  auth_engine_model auth_engine_model_inst (.clk(clk), .rst(rst), .authStart(authStart),
    .delay(dly), .respLen(respLen), .authDone(authDone), .authRespLen(authRespLen));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic tally_and_finish;
    $display("compared %0d, mismatched %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic chk);
    addr <= a;
    rdStb <= 1'b1;
    rdChk <= chk;
    if (chk) expQ.push_back(e);
    @(posedge clk);
    rdStb <= 1'b0;
    rdChk <= 1'b0;
    // data stand in this cycle only; taken before the edge updates them
    @(posedge clk);
    rdLast = rdData;
  endtask : rd

  // issue a command, poll until idle, then check the status word
  task automatic ex(input logic [31:0] c, input logic [15:0] sw);
    int i;
    logic b;
    wr(`REG_CMD, c);
    b = 1'b1;
    for (i = 0; i < 300 && b !== 1'b0; i++) begin
      rd(`REG_STATUS, 32'h0, 1'b0);
      b = rdLast[`F_BUSY];
    end
    rd(`REG_STATUS, {16'h0000, sw}, 1'b1);
  endtask : ex

  function automatic logic [31:0] cw(input logic [2:0] o, input logic [7:0] p1,
                                     input logic [7:0] p2, input logic [7:0] len,
                                     input logic [3:0] t, input logic le);
    return {le, o, t, len, p2, p1};
  endfunction : cw

  task automatic note(input string s);
    $display("test %s finished", s);
  endtask : note

  ////////////////////////////////////////////////////////////////////////////////
  // read monitor: the data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (pend) cmp(rdData, expQ.pop_front());
    pend <= rdStb && rdChk;
    if (authStart === 1'b1) nStart++;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  initial begin
    int i;
    void'($urandom(32'ha4de));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 10; i++) rd(8'(i * 4), (i == 2) ? 32'h9000 : 32'h0, 1'b1);
    wr(`REG_STATUS, 32'hffff_ffff);
    wr(8'h24, 32'hffff_ffff);
    rd(`REG_STATUS, 32'h9000, 1'b1);
    rd(8'h24, 32'h0, 1'b1);
    wr(`REG_DEACT_OK, 32'h0070);
    rd(`REG_DEACT_OK, 32'h0070, 1'b1);
    note("reset");
    ex(cw(card_cmd_pkg::OP_UNBLOCK, 8'h00, 8'h01, 8'h10, 4'h0, 1'b0), `SW_OK);
    ex(cw(card_cmd_pkg::OP_UNBLOCK, 8'h00, 8'h01, 8'h00, 4'h0, 1'b0), `SW_OK);
    ex(cw(card_cmd_pkg::OP_UNBLOCK, 8'h00, 8'h01, 8'h08, 4'h0, 1'b0), `SW_WRONG_LEN);
    ex(cw(card_cmd_pkg::OP_UNBLOCK, 8'h01, 8'h01, 8'h10, 4'h0, 1'b0), `SW_BAD_P1P2);
    ex(cw(card_cmd_pkg::OP_UNBLOCK, 8'h00, 8'h01, 8'h10, 4'h0, 1'b1), `SW_BAD_P1P2);
    note("unblock");
    wr(`REG_ARG, 32'h0200_0000);
    ex(cw(card_cmd_pkg::OP_SELECT, 8'h00, 8'h00, 8'h02, 4'h3, 1'b0), `SW_OK);
    ex(cw(card_cmd_pkg::OP_DEACT, 8'h00, 8'h00, 8'h02, 4'h8, 1'b0), `SW_SECURITY);
    rd(`REG_LIFE, 32'h0, 1'b1);
    ex(cw(card_cmd_pkg::OP_DEACT, 8'h01, 8'h00, 8'h02, 4'h4, 1'b0), `SW_BAD_P1P2);
    ex(cw(card_cmd_pkg::OP_DEACT, 8'h00, 8'h01, 8'h02, 4'h4, 1'b0), `SW_BAD_P1P2);
    ex(cw(card_cmd_pkg::OP_DEACT, 8'h00, 8'h00, 8'h02, 4'h4, 1'b1), `SW_BAD_P1P2);
    rd(`REG_FILE, 32'h23, 1'b1);
    for (i = 0; i < 3; i++) begin
      ex(cw(card_cmd_pkg::OP_DEACT, p1s[i], 8'h00, 8'h02, 4'(4 + i), 1'b0), `SW_OK);
      rd(`REG_LIFE, ((32'h1 << (i + 1)) - 32'h1) << 4, 1'b1);
      rd(`REG_FILE, 32'h20 + 32'(4 + i), 1'b1);
    end
    ex(cw(card_cmd_pkg::OP_OTHER, 8'h00, 8'h00, 8'h02, 4'h6, 1'b0), `SW_DEAD_FILE);
    ex(cw(card_cmd_pkg::OP_OTHER, 8'h00, 8'h00, 8'h02, 4'h7, 1'b0), `SW_OK);
    ex(cw(card_cmd_pkg::OP_SELECT, 8'h00, 8'h00, 8'h02, 4'h4, 1'b0), `SW_OK);
    ex(cw(card_cmd_pkg::OP_ACT, 8'h00, 8'h00, 8'h00, 4'h9, 1'b0), `SW_SECURITY);
    rd(`REG_FILE, 32'h24, 1'b1);
    wr(`REG_ACT_OK, 32'h0010);
    ex(cw(card_cmd_pkg::OP_ACT, 8'h00, 8'h00, 8'h00, 4'h9, 1'b0), `SW_OK);
    rd(`REG_LIFE, 32'h60, 1'b1);
    rd(`REG_FILE, 32'h24, 1'b1);
    note("files");
    ex(cw(card_cmd_pkg::OP_AUTH_EVEN, 8'h00, 8'h00, 8'h10, 4'h0, 1'b0), `SW_SEQUENCE);
    wr(`REG_CTRL, 32'h1);
    rd(`REG_CTRL, 32'h1, 1'b1);
    ex(cw(card_cmd_pkg::OP_AUTH_EVEN, 8'h00, 8'h00, 8'h10, 4'h0, 1'b0), `SW_OK);
    cmp(32'(nStart), 32'h1);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'h00, 8'h00, 8'h2d, 4'h0, 1'b0), `SW_SEQUENCE);
    wr(`REG_ARG, 32'h0011_012c);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'h80, 8'h00, 8'hff, 4'h0, 1'b0), `SW_BAD_DATA);
    wr(`REG_ARG, 32'h0073_012c);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'h80, 8'h00, 8'hff, 4'h0, 1'b0), `SW_DATA_MORE);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'h40, 8'h00, 8'hff, 4'h0, 1'b0), `SW_DATA_MORE);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'h00, 8'h00, 8'h2d, 4'h0, 1'b0), `SW_DATA_DONE);
    dly <= 8'($urandom_range(30, 5));
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'ha0, 8'h00, 8'h00, 4'h0, 1'b1), `SW_RESP_MORE);
    cmp(32'(nStart), 32'h2);
    rd(`REG_RESP, 32'h0100_0000, 1'b1);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'h60, 8'h00, 8'h00, 4'h0, 1'b1), `SW_RESP_MORE);
    rd(`REG_RESP, 32'h0100_0000, 1'b1);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'h20, 8'h00, 8'h00, 4'h0, 1'b1), `SW_OK);
    rd(`REG_RESP, 32'h002c_0100, 1'b1);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'h20, 8'h00, 8'h00, 4'h0, 1'b1), `SW_SEQUENCE);
    cmp(32'(nStart), 32'h2);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'ha0, 8'h00, 8'h00, 4'h0, 1'b1), `SW_SEQUENCE);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'hc0, 8'h00, 8'h00, 4'h0, 1'b1), `SW_BAD_P1P2);
    ex(cw(card_cmd_pkg::OP_AUTH_EVEN, 8'h01, 8'h00, 8'h10, 4'h0, 1'b0), `SW_BAD_P1P2);
    ex(cw(card_cmd_pkg::OP_SPARE, 8'h00, 8'h00, 8'h00, 4'h0, 1'b0), `SW_BAD_P1P2);
    note("chain");
    wr(`REG_ARG, 32'h0053_000a);
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'h80, 8'h00, 8'h0a, 4'h0, 1'b0), `SW_DATA_DONE);
    respLen <= 16'($urandom_range(256, 1));
    dly <= 8'h00;
    ex(cw(card_cmd_pkg::OP_AUTH_ODD, 8'ha0, 8'h00, 8'h00, 4'h0, 1'b1), `SW_OK);
    rd(`REG_RESP, {7'h00, respLen[8:0], 16'h0000}, 1'b1);
    note("short chain");
    repeat (3) @(posedge clk);
    tally_and_finish;
  end

endmodule : card_file_state_and_auth_chaining_test
